// *** hw/fcs_pkg.sv ***
/*
 package for the fifo channel select block: register map, field layout,
 encodings of channel codes and fill policies, and the carrier structs.
 assumes nothing beyond a systemverilog compiler.
*/
package fcs_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_FIFO_SETUP   = 8'h28; // fifo setup register
	localparam logic [7:0] ADDR_FIFO_SAMPLES = 8'h29; // watermark low byte
	localparam logic [7:0] ADDR_TEMP_CFG     = 8'h3D; // temperature enable holder
	localparam logic [7:0] ADDR_CONV_CFG     = 8'h3C; // converter enable holder
	localparam logic [7:0] ADDR_STATUS       = 8'h2B; // own status register
	localparam logic [7:0] RST_FIFO_SETUP    = 8'h00;
	localparam logic [7:0] RST_FIFO_SAMPLES  = 8'h80;
	localparam logic [7:0] RST_ZERO          = 8'h00;

	// ==========================================================
	// field positions of the fifo setup register
	localparam int POL_LSB   = 0; // fill policy [1:0]
	localparam int WM_MSB_B  = 2; // watermark bit 8
	localparam int CHAN_LSB  = 3; // channel select [6:3]
	localparam int RSVD_B    = 7; // reserved bit
	localparam int EN_B      = 0; // enable bit in temp/conv holders

	// ==========================================================
	// channel codes
	localparam logic [3:0] CH_XYZ    = 4'h0;
	localparam logic [3:0] CH_X      = 4'h1;
	localparam logic [3:0] CH_Y      = 4'h2;
	localparam logic [3:0] CH_Z      = 4'h3;
	localparam logic [3:0] CH_XYZ_T  = 4'h4;
	localparam logic [3:0] CH_X_T    = 4'h5;
	localparam logic [3:0] CH_Y_T    = 4'h6;
	localparam logic [3:0] CH_Z_T    = 4'h7;
	localparam logic [3:0] CH_XYZ_A  = 4'h8;
	localparam logic [3:0] CH_X_A    = 4'h9;
	localparam logic [3:0] CH_Y_A    = 4'hA;
	localparam logic [3:0] CH_Z_A    = 4'hB;

	// fill policies
	typedef enum logic [1:0] {
		FCS_POL_OFF    = 2'h0, // disabled
		FCS_POL_OLDEST = 2'h1, // keep oldest, stop when full
		FCS_POL_STREAM = 2'h2, // drop oldest
		FCS_POL_TRIG   = 2'h3  // capture around an event
	} fcs_policy_e;

	// entry tags written beside each fifo word
	localparam logic [1:0] TAG_X   = 2'h0;
	localparam logic [1:0] TAG_Y   = 2'h1;
	localparam logic [1:0] TAG_Z   = 2'h2;
	localparam logic [1:0] TAG_AUX = 2'h3;

	localparam int SAMPLE_W = 14; // converter result width
	localparam int WM_W     = 9;  // watermark set count width

	// ==========================================================
	// carriers
	typedef struct packed {
		logic x;
		logic y;
		logic z;
		logic temp;
		logic conv;
	} fcs_chan_s;

	typedef struct packed {
		logic [SAMPLE_W-1:0] x;
		logic [SAMPLE_W-1:0] y;
		logic [SAMPLE_W-1:0] z;
		logic [SAMPLE_W-1:0] temp;
		logic [SAMPLE_W-1:0] conv;
	} fcs_set_s;

	typedef struct packed {
		logic                valid;
		logic [1:0]          tag;
		logic [SAMPLE_W-1:0] data;
	} fcs_entry_s;
endpackage

// *** hw/fcs_decode.sv ***
/*
 channel code decoder: turns the four-bit channel select code and the
 temperature / converter enables into a set of channel enables.
 assumes the code is stable while conversions run.
*/
`timescale 1ns/10ps
module fcs_decode (
	input  wire logic [3:0]        code_i,     // channel select field
	input  wire logic              temp_en_i,  // temperature measurement enabled
	input  wire logic              conv_en_i,  // external converter enabled
	output fcs_pkg::fcs_chan_s     chan_o,     // decoded enables
	output logic                   illegal_o   // code is reserved
);
	// ==========================================================
	// decode
	// comb decode; reserved codes fall back to no channels so nothing is stored
	always_comb begin
		chan_o    = '0;
		illegal_o = 1'b0;
		unique case (code_i)
			fcs_pkg::CH_XYZ:   begin chan_o.x = 1'b1; chan_o.y = 1'b1; chan_o.z = 1'b1; end
			fcs_pkg::CH_X:     chan_o.x = 1'b1;
			fcs_pkg::CH_Y:     chan_o.y = 1'b1;
			fcs_pkg::CH_Z:     chan_o.z = 1'b1;
			fcs_pkg::CH_XYZ_T: begin chan_o.x = 1'b1; chan_o.y = 1'b1; chan_o.z = 1'b1; chan_o.temp = temp_en_i; end
			fcs_pkg::CH_X_T:   begin chan_o.x = 1'b1; chan_o.temp = temp_en_i; end
			fcs_pkg::CH_Y_T:   begin chan_o.y = 1'b1; chan_o.temp = temp_en_i; end
			fcs_pkg::CH_Z_T:   begin chan_o.z = 1'b1; chan_o.temp = temp_en_i; end
			fcs_pkg::CH_XYZ_A: begin chan_o.x = 1'b1; chan_o.y = 1'b1; chan_o.z = 1'b1; chan_o.conv = conv_en_i; end
			fcs_pkg::CH_X_A:   begin chan_o.x = 1'b1; chan_o.conv = conv_en_i; end
			fcs_pkg::CH_Y_A:   begin chan_o.y = 1'b1; chan_o.conv = conv_en_i; end
			fcs_pkg::CH_Z_A:   begin chan_o.z = 1'b1; chan_o.conv = conv_en_i; end
			default:           illegal_o = 1'b1; // reserved codes
		endcase
	end
endmodule

// *** hw/fcs_top.sv ***
/*
 fifo channel select block: holds the fifo setup register and friends,
 decodes which channels are converted, and serialises each sample set into
 fifo entries in a fixed order.
 assumes one clock, synchronous inputs, and a fifo downstream that takes
 one entry per enabled cycle while its ready is high.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module fcs_top (
	input  wire logic                 core_clk_i,     // block clock, 50 MHz
	input  wire logic                 sys_rst_i,      // synchronous reset, active high
	input  wire logic                 clk_en_i,       // freezes all state when low
	// register port
	input  wire logic [7:0]           reg_addr_i,     // register address
	input  wire logic [7:0]           reg_wdata_i,    // write data
	input  wire logic                 reg_wr_i,       // write strobe
	input  wire logic                 reg_rd_i,       // read strobe
	output logic      [7:0]           reg_rdata_o,    // read data, one cycle later
	// sample pipeline
	input  wire logic                 set_valid_i,    // a converted set is offered
	input  wire fcs_pkg::fcs_set_s    set_i,          // converted results
	output logic                      set_ready_o,    // set taken this cycle
	output fcs_pkg::fcs_chan_s        conv_en_o,      // channels to convert
	output fcs_pkg::fcs_policy_e      policy_o,       // fill policy to fifo logic
	output logic      [fcs_pkg::WM_W-1:0] watermark_o, // watermark, in sets
	output logic      [fcs_pkg::WM_W+1:0] wm_entries_o, // watermark, in entries
	// fifo write side
	output fcs_pkg::fcs_entry_s       entry_o,        // entry to fifo
	input  wire logic                 entry_ready_i   // fifo takes entry
);
	// ==========================================================
	// state
	typedef enum logic [1:0] {
		FCS_IDLE = 2'b01, // waiting for a set
		FCS_EMIT = 2'b10  // writing entries of the held set
	} fcs_state_e;

	typedef struct packed {
		logic [7:0]          setup;     // fifo setup register
		logic [7:0]          samples;   // watermark low byte
		logic [7:0]          temp_cfg;  // temperature enable holder
		logic [7:0]          conv_cfg;  // converter enable holder
		logic [7:0]          rdata;     // read data register
		fcs_state_e          state;     // serialiser state
		fcs_pkg::fcs_chan_s  pend;      // channels still to write
		fcs_pkg::fcs_set_s   held;      // captured set
		fcs_pkg::fcs_entry_s entry;     // entry on the fifo port
		logic                bad_code;  // sticky reserved code seen
		logic [7:0]          sets_done; // wrapping count of finished sets
	} fcs_regs_s;

	fcs_regs_s r;       // registered state
	fcs_regs_s next_r;  // next value

	fcs_pkg::fcs_chan_s chan;    // decoded enables
	logic               illegal; // reserved code present

	// ==========================================================
	// decoder
	fcs_decode u_decode (
		.code_i    (r.setup[fcs_pkg::CHAN_LSB +: 4]),
		.temp_en_i (r.temp_cfg[fcs_pkg::EN_B]),
		.conv_en_i (r.conv_cfg[fcs_pkg::EN_B]),
		.chan_o    (chan),
		.illegal_o (illegal)
	);

	// ==========================================================
	// helpers
	// count of enabled channels, used for watermark scaling
	function automatic logic [2:0] chan_count(input fcs_pkg::fcs_chan_s c);
		chan_count = 3'(c.x) + 3'(c.y) + 3'(c.z) + 3'(c.temp) + 3'(c.conv);
	endfunction

	// first channel still pending, in fixed write order
	function automatic logic [1:0] first_tag(input fcs_pkg::fcs_chan_s c);
		if (c.x) begin
			first_tag = fcs_pkg::TAG_X;
		end else if (c.y) begin
			first_tag = fcs_pkg::TAG_Y;
		end else if (c.z) begin
			first_tag = fcs_pkg::TAG_Z;
		end else begin
			first_tag = fcs_pkg::TAG_AUX;
		end
	endfunction

	// ==========================================================
	// next state
	// all state moves together; entry stands until the fifo takes it
	always_comb begin
		next_r = r;
		// register writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				fcs_pkg::ADDR_FIFO_SETUP:   next_r.setup    = reg_wdata_i;
				fcs_pkg::ADDR_FIFO_SAMPLES: next_r.samples  = reg_wdata_i;
				fcs_pkg::ADDR_TEMP_CFG:     next_r.temp_cfg = reg_wdata_i;
				fcs_pkg::ADDR_CONV_CFG:     next_r.conv_cfg = reg_wdata_i;
				default:                    next_r.bad_code = r.bad_code; // unmapped writes ignored
			endcase
		end
		// reads: data stand one cycle only
		next_r.rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				fcs_pkg::ADDR_FIFO_SETUP:   next_r.rdata = r.setup;
				fcs_pkg::ADDR_FIFO_SAMPLES: next_r.rdata = r.samples;
				fcs_pkg::ADDR_TEMP_CFG:     next_r.rdata = r.temp_cfg;
				fcs_pkg::ADDR_CONV_CFG:     next_r.rdata = r.conv_cfg;
				fcs_pkg::ADDR_STATUS:       next_r.rdata = {r.sets_done[6:0], r.bad_code};
				default:                    next_r.rdata = 8'h00; // unmapped reads zero
			endcase
		end
		// sticky reserved flag; reading status clears, a new hit wins
		if (reg_rd_i && reg_addr_i == fcs_pkg::ADDR_STATUS) begin
			next_r.bad_code = 1'b0;
		end
		if (illegal) begin
			next_r.bad_code = 1'b1;
		end
		// entry handshake: drop the valid once taken
		if (r.entry.valid && entry_ready_i) begin
			next_r.entry.valid = 1'b0;
		end
		// serialiser
		unique case (r.state)
			FCS_IDLE: begin
				// a disabled policy stores nothing
				if (set_valid_i && policy_o != fcs_pkg::FCS_POL_OFF && !illegal) begin
					next_r.held  = set_i;
					next_r.pend  = chan;
					next_r.state = FCS_EMIT;
				end
			end
			FCS_EMIT: begin
				// leave only once the last entry is taken, so a new set never overlaps a stalled one
				if (r.pend == '0 && (!r.entry.valid || entry_ready_i)) begin
					next_r.state     = FCS_IDLE;
					next_r.sets_done = r.sets_done + 8'h01;
				end else if (!r.entry.valid || entry_ready_i) begin
					// fixed order x, y, z then extra
					next_r.entry.valid = 1'b1;
					next_r.entry.tag   = first_tag(r.pend);
					unique case (first_tag(r.pend))
						fcs_pkg::TAG_X: begin
							next_r.entry.data = r.held.x;
							next_r.pend.x     = 1'b0;
						end
						fcs_pkg::TAG_Y: begin
							next_r.entry.data = r.held.y;
							next_r.pend.y     = 1'b0;
						end
						fcs_pkg::TAG_Z: begin
							next_r.entry.data = r.held.z;
							next_r.pend.z     = 1'b0;
						end
						fcs_pkg::TAG_AUX: begin
							// temperature ahead of converter; never both at once
							if (r.pend.temp) begin
								next_r.entry.data = r.held.temp;
								next_r.pend.temp  = 1'b0;
							end else begin
								next_r.entry.data = r.held.conv;
								next_r.pend.conv  = 1'b0;
							end
						end
					endcase
				end
			end
			default: next_r.state = FCS_IDLE; // recover from a broken code
		endcase
	end

	// ==========================================================
	// registers
	// synchronous reset to constants; clock enable freezes everything
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			r          <= '0;
			r.setup    <= fcs_pkg::RST_FIFO_SETUP;
			r.samples  <= fcs_pkg::RST_FIFO_SAMPLES;
			r.temp_cfg <= fcs_pkg::RST_ZERO;
			r.conv_cfg <= fcs_pkg::RST_ZERO;
			r.state    <= FCS_IDLE;
		end else if (clk_en_i) begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata_o  = r.rdata;
	assign entry_o      = r.entry;
	assign conv_en_o    = chan;
	assign policy_o     = fcs_pkg::fcs_policy_e'(r.setup[fcs_pkg::POL_LSB +: 2]);
	// ninth watermark bit sits in the setup register
	assign watermark_o  = {r.setup[fcs_pkg::WM_MSB_B], r.samples};
	// sets times entries per set; reserved bit plays no part here
	assign wm_entries_o = 11'(watermark_o * chan_count(chan));
	// a set is taken only in idle, with a live policy and legal code
	assign set_ready_o  = clk_en_i && r.state == FCS_IDLE && policy_o != fcs_pkg::FCS_POL_OFF && !illegal;
endmodule

// *** dv/fcs_top_checker.sv ***
/*
 checker for fcs_top: register readback, decode, refusal and entry timing.
 assumes it is bound to fcs_top and sees only the top module's ports.
*/
`timescale 1ns/10ps
module fcs_top_checker (
	input wire logic                 core_clk_i,
	input wire logic                 sys_rst_i,
	input wire logic                 clk_en_i,
	input wire logic [7:0]           reg_addr_i,
	input wire logic [7:0]           reg_wdata_i,
	input wire logic                 reg_wr_i,
	input wire logic                 reg_rd_i,
	input wire logic [7:0]           reg_rdata_o,
	input wire logic                 set_valid_i,
	input wire logic                 set_ready_o,
	input wire fcs_pkg::fcs_chan_s   conv_en_o,
	input wire fcs_pkg::fcs_policy_e policy_o,
	input wire fcs_pkg::fcs_entry_s  entry_o,
	input wire logic                 entry_ready_i
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// shadow of the setup register, so decode can be judged
	logic [7:0] setup; // last value written to the setup register
	wire  [3:0] code = setup[6:3]; // channel select field
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			setup <= 8'h00;
		end else if (clk_en_i && reg_wr_i && reg_addr_i == fcs_pkg::ADDR_FIFO_SETUP) begin
			setup <= reg_wdata_i;
		end
	end
	// ==========================================================
	// assertions
	chk_setup_readback: assert property (reg_rd_i && reg_addr_i == fcs_pkg::ADDR_FIFO_SETUP |=>
		reg_rdata_o == $past(setup)) else $error("setup readback differs");
	chk_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h30 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_policy_follow: assert property (policy_o == setup[1:0])
		else $error("policy differs from register");
	chk_axis_decode: assert property (code < 4'hC |-> conv_en_o.x == (code[1:0] inside {2'h0, 2'h1})
		&& conv_en_o.y == (code[1:0] inside {2'h0, 2'h2}) && conv_en_o.z == (code[1:0] inside {2'h0, 2'h3}))
		else $error("axis enables wrong");
	chk_refuse_set: assert property (policy_o == fcs_pkg::FCS_POL_OFF || code >= 4'hC |-> !set_ready_o)
		else $error("set taken while refused");
	chk_entry_start: assert property (set_valid_i && set_ready_o |=> ##[0:2] entry_o.valid)
		else $error("no entry after set taken");
	chk_entry_hold: assert property (entry_o.valid && !entry_ready_i |=> entry_o.valid && $stable(entry_o))
		else $error("entry dropped while stalled");
	chk_busy_no_take: assert property (entry_o.valid |-> !set_ready_o)
		else $error("set taken while emitting");
endmodule

bind fcs_top fcs_top_checker i_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .set_valid_i(set_valid_i), .set_ready_o(set_ready_o), .conv_en_o(conv_en_o),
	.policy_o(policy_o), .entry_o(entry_o), .entry_ready_i(entry_ready_i));

// *** dv/fcs_sink_model.sv ***
/*
 downstream fifo model: takes entries, stalling one cycle in four.
 assumes the bench reads and clears its queue of taken entries.
*/
`timescale 1ns/10ps
module fcs_sink_model (
	input  wire logic                core_clk_i,
	input  wire logic                sys_rst_i,
	input  wire fcs_pkg::fcs_entry_s entry_i,
	output logic                     ready_o
);
	fcs_pkg::fcs_entry_s got[$]; // entries taken, in order
	logic [1:0]          phase;  // stall pattern counter
	// stall now and then so entries must stand while refused
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			phase <= 2'h0;
			ready_o <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			ready_o <= (phase != 2'h3);
			if (entry_i.valid && ready_o) begin
				got.push_back(entry_i);
			end
		end
	end
endmodule

// *** dv/tb_top.sv ***
/*
 testbench for fcs_top: register map, every legal channel code, enables, watermark,
 policies and reserved code 4'hC. assumes the bound checker and the sink model.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
	logic core_clk_i, sys_rst_i, clk_en_i, reg_wr_i, reg_rd_i, set_valid_i, entry_ready_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
	logic set_ready_o;
	logic [8:0] watermark_o;
	logic [10:0] wm_entries_o;
	fcs_pkg::fcs_set_s set_i;
	fcs_pkg::fcs_chan_s conv_en_o;
	fcs_pkg::fcs_policy_e policy_o;
	fcs_pkg::fcs_entry_s entry_o;
	int miscompares = 0;
	int cmp_count = 0;

	fcs_top i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.set_valid_i(set_valid_i), .set_i(set_i), .set_ready_o(set_ready_o), .conv_en_o(conv_en_o),
		.policy_o(policy_o), .watermark_o(watermark_o), .wm_entries_o(wm_entries_o), .entry_o(entry_o),
		.entry_ready_i(entry_ready_i));
	fcs_sink_model i_sink (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .entry_i(entry_o), .ready_o(entry_ready_i));

	always #10 core_clk_i = ~core_clk_i;

	// ==========================================================
	// bus tasks: strobes last one cycle, read data taken in the slot after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		d = reg_rdata_o;
	endtask
	// offer one set, then judge the entries against the expected order
	task automatic send_set(input logic [3:0] code, input logic aux_on);
		fcs_pkg::fcs_entry_s exp[$];
		fcs_pkg::fcs_set_s st;
		int n;
		st = {14'h1100 | code, 14'h2200 | code, 14'h3300 | code, 14'h0444, 14'h0555};
		if (code[1:0] inside {2'h0, 2'h1}) exp.push_back({1'b1, fcs_pkg::TAG_X, st.x});
		if (code[1:0] inside {2'h0, 2'h2}) exp.push_back({1'b1, fcs_pkg::TAG_Y, st.y});
		if (code[1:0] inside {2'h0, 2'h3}) exp.push_back({1'b1, fcs_pkg::TAG_Z, st.z});
		if (aux_on && code[3:2] == 2'h1) exp.push_back({1'b1, fcs_pkg::TAG_AUX, st.temp});
		if (aux_on && code[3:2] == 2'h2) exp.push_back({1'b1, fcs_pkg::TAG_AUX, st.conv});
		i_sink.got.delete();
		@(posedge core_clk_i);
		set_i <= st;
		set_valid_i <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk_i);
			n++;
		end while (!set_ready_o && n < 20);
		@(posedge core_clk_i);
		set_valid_i <= 1'b0;
		// wait for the whole set, then a few more cycles for strays
		n = 0;
		while (i_sink.got.size() < exp.size() && n < 40) begin
			@(posedge core_clk_i);
			n++;
		end
		repeat (4) @(posedge core_clk_i);
		`CHK(i_sink.got.size(), exp.size())
		foreach (exp[k]) `CHK(i_sink.got[k], exp[k])
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk_i);
		miscompares++;
		wrap_up();
	end

	// ==========================================================
	// main sequence
	initial begin
		core_clk_i = 1'b0;
		sys_rst_i = 1'b1;
		clk_en_i = 1'b1;
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, set_valid_i} = '0;
		set_i = '0;
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd(fcs_pkg::ADDR_FIFO_SETUP, v);
		`CHK(v, fcs_pkg::RST_FIFO_SETUP)
		rd(fcs_pkg::ADDR_FIFO_SAMPLES, v);
		`CHK(v, fcs_pkg::RST_FIFO_SAMPLES)
		rd(8'h30, v);
		`CHK(v, 8'h00)
		`CHK(set_ready_o, 1'b0)
		wr(fcs_pkg::ADDR_TEMP_CFG, 8'h01);
		wr(fcs_pkg::ADDR_CONV_CFG, 8'h01);
		// every legal code, reserved bit set to show it changes nothing
		for (int c = 0; c < 12; c++) begin
			wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b1, c[3:0], 1'b0, 2'h1});
			rd(fcs_pkg::ADDR_FIFO_SETUP, v);
			`CHK(v, {1'b1, c[3:0], 3'h1})
			send_set(c[3:0], 1'b1);
		end
		// extras disabled: axes only
		wr(fcs_pkg::ADDR_TEMP_CFG, 8'h00);
		wr(fcs_pkg::ADDR_CONV_CFG, 8'h00);
		wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_XYZ_T, 3'h1});
		send_set(fcs_pkg::CH_XYZ_T, 1'b0);
		wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_Y_A, 3'h1});
		send_set(fcs_pkg::CH_Y_A, 1'b0);
		// watermark with its top bit, counted in sets and in entries
		wr(fcs_pkg::ADDR_FIFO_SAMPLES, 8'h02);
		wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_XYZ, 1'b1, 2'h2});
		@(negedge core_clk_i);
		`CHK(watermark_o, 9'h102)
		`CHK(wm_entries_o, 11'h306)
		for (int p = 0; p < 4; p++) begin
			// pass through the disabled policy between two policies
			wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_XYZ, 3'h0});
			wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_XYZ, 1'b0, p[1:0]});
			@(negedge core_clk_i);
			`CHK(policy_o, p[1:0])
		end
		// reserved code: set refused and flagged in status
		wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, 4'hC, 3'h1});
		@(posedge core_clk_i);
		set_valid_i <= 1'b1;
		@(negedge core_clk_i);
		`CHK(set_ready_o, 1'b0)
		@(posedge core_clk_i);
		set_valid_i <= 1'b0;
		rd(fcs_pkg::ADDR_STATUS, v);
		`CHK(v[0], 1'b1)
		`CHK(v[7:1], 7'h0E)
		// legal code again: the flag holds until a status read clears it
		wr(fcs_pkg::ADDR_FIFO_SETUP, {1'b0, fcs_pkg::CH_XYZ, 3'h1});
		rd(fcs_pkg::ADDR_STATUS, v);
		`CHK(v[0], 1'b1)
		rd(fcs_pkg::ADDR_STATUS, v);
		`CHK(v[0], 1'b0)
		wrap_up();
	end
endmodule
